//--- hdl/pin_sel_pkg.sv
// constants, apb carrier and pin maps for the timer and interrupt pin select block
//
// Contract
// - split bit 7 clear shares P26; set captures from P27, compare on P26.
// - split bit 6 clear shares P25; set captures from P24, compare on P25.
// - split bit 5 clear shares P21; set captures from P20, compare on P21.
// - split bit 4 clear shares P22; set captures from P23, compare on P22.
// - split bit 3 clear shares P36; set captures from P37, compare on P36.
// - split bit 2 clear shares P34; set captures from P35, compare on P34.
// - split bit 1 clear shares P30; set captures from P31, compare on P30.
// - split bit 0 clear shares P32; set captures from P33, compare on P32.
// - upper four bits of interrupt select read zero; software writes zero.
// - interrupt select bit 3 routes line 11 from P23, or P63 when set.
// - interrupt select bit 2 routes line 10 from P22, or P62 when set.
// - interrupt select bit 1 routes line 9 from P21, or P61 when set.
// - interrupt select bit 0 routes line 8 from P20, or P60 when set.
package pin_sel_pkg;

    localparam int             TMR_FUNCS        = 8;
    localparam int             IRQ_LINES        = 4;
    localparam int             PIN_COUNT        = 16;
    localparam int             ADDR_W           = 12;
    localparam int             DATA_W           = 32;

    localparam logic [11:0]    ADDR_TIMER_SEL   = 12'h000;
    localparam logic [11:0]    ADDR_IRQ_SEL     = 12'h004;

    localparam logic [7:0]     TIMER_SEL_RESET  = 8'h00;
    localparam logic [3:0]     IRQ_SEL_RESET    = 4'h0;
    localparam logic [31:0]    RDATA_IDLE       = 32'h00000000;

    // pin index: port 2 bit n is n, port 3 bit n is 8 + n
    localparam logic [3:0]     PRI_PIN [TMR_FUNCS] = '{4'hA, 4'h8, 4'hC, 4'hE, 4'h2, 4'h1, 4'h5, 4'h6};
    localparam logic [3:0]     SEC_PIN [TMR_FUNCS] = '{4'hB, 4'h9, 4'hD, 4'hF, 4'h3, 4'h0, 4'h4, 4'h7};

    typedef enum logic [1:0] {
        HIT_NONE  = 2'h0,
        HIT_TIMER = 2'h1,
        HIT_IRQ   = 2'h2
    } reg_hit_e;

    typedef struct packed {
        logic                  psel;
        logic                  penable;
        logic                  pwrite;
        logic [ADDR_W-1:0]     paddr;
        logic [DATA_W-1:0]     pwdata;
    } apb_req_s;

endpackage

//--- hdl/timer_and_irq_pin_select.sv
// apb-programmed pin select for timer compare/capture and high external interrupts
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module timer_and_irq_pin_select (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_b,
    input  wire pin_sel_pkg::apb_req_s i_apb,
    output logic                       o_pready,
    output logic [31:0]                o_prdata,
    output logic                       o_pslverr,
    input  wire logic [7:0]            i_port2_in,
    input  wire logic [7:0]            i_port3_in,
    input  wire logic [3:0]            i_port6_in,
    input  wire logic [7:0]            i_cmp_out,
    input  wire logic [7:0]            i_cmp_oe,
    output logic [7:0]                 o_capture,
    output logic [7:0]                 o_port2_out,
    output logic [7:0]                 o_port2_oe,
    output logic [7:0]                 o_port3_out,
    output logic [7:0]                 o_port3_oe,
    output logic [3:0]                 o_ext_int
);

    logic [7:0]                        timer_pin_split_select;
    logic [3:0]                        irq_high_pin_select;
    logic [15:0]                       pin_in;
    logic [15:0]                       next_pin_out;
    logic [15:0]                       next_pin_oe;
    logic [7:0]                        next_capture;
    logic                              setup;
    logic                              access;
    pin_sel_pkg::reg_hit_e             hit;

    function automatic pin_sel_pkg::reg_hit_e addr_hit(input logic [11:0] addr);
        if (addr == pin_sel_pkg::ADDR_TIMER_SEL) begin
            return pin_sel_pkg::HIT_TIMER;
        end else if (addr == pin_sel_pkg::ADDR_IRQ_SEL) begin
            return pin_sel_pkg::HIT_IRQ;
        end
        return pin_sel_pkg::HIT_NONE;
    endfunction

    assign pin_in = {i_port3_in, i_port2_in};
    assign setup  = i_apb.psel && !i_apb.penable;
    assign access = i_apb.psel && i_apb.penable && o_pready;
    assign hit    = addr_hit(i_apb.paddr);

    // split select register; bits steer routing from the next edge on
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            timer_pin_split_select <= pin_sel_pkg::TIMER_SEL_RESET;
        end else if (access && i_apb.pwrite && hit == pin_sel_pkg::HIT_TIMER) begin
            timer_pin_split_select <= i_apb.pwdata[7:0];
        end
    end

    // only four bits are stored, so the reserved upper bits cannot stick
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            irq_high_pin_select <= pin_sel_pkg::IRQ_SEL_RESET;
        end else if (access && i_apb.pwrite && hit == pin_sel_pkg::HIT_IRQ) begin
            irq_high_pin_select <= i_apb.pwdata[3:0];
        end
    end

    // zero-wait slave: answer prepared in setup so outputs stay registered
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= pin_sel_pkg::RDATA_IDLE;
        end else begin
            o_pready  <= setup;
            o_pslverr <= setup && hit == pin_sel_pkg::HIT_NONE;
            o_prdata  <= pin_sel_pkg::RDATA_IDLE;
            if (setup && !i_apb.pwrite) begin
                case (hit)
                    pin_sel_pkg::HIT_TIMER: o_prdata <= {24'h000000, timer_pin_split_select};
                    pin_sel_pkg::HIT_IRQ:   o_prdata <= {28'h0000000, irq_high_pin_select};
                    default:                o_prdata <= pin_sel_pkg::RDATA_IDLE;
                endcase
            end
        end
    end

    // compare always owns the primary pin; secondary pins are left to the port
    always_comb begin
        next_pin_out = 16'h0000;
        next_pin_oe  = 16'h0000;
        next_capture = 8'h00;
        for (int k = 0; k < pin_sel_pkg::TMR_FUNCS; k++) begin
            next_pin_out[pin_sel_pkg::PRI_PIN[k]] = i_cmp_out[k];
            next_pin_oe[pin_sel_pkg::PRI_PIN[k]]  = i_cmp_oe[k];
            next_capture[k] = timer_pin_split_select[k] ? pin_in[pin_sel_pkg::SEC_PIN[k]]
                                                        : pin_in[pin_sel_pkg::PRI_PIN[k]];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_capture   <= 8'h00;
            o_port2_out <= 8'h00;
            o_port2_oe  <= 8'h00;
            o_port3_out <= 8'h00;
            o_port3_oe  <= 8'h00;
        end else begin
            o_capture   <= next_capture;
            o_port2_out <= next_pin_out[7:0];
            o_port2_oe  <= next_pin_oe[7:0];
            o_port3_out <= next_pin_out[15:8];
            o_port3_oe  <= next_pin_oe[15:8];
        end
    end

    // one registered stage; interrupt edge detection downstream sees one cycle delay
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_ext_int <= 4'h0;
        end else begin
            for (int j = 0; j < pin_sel_pkg::IRQ_LINES; j++) begin
                o_ext_int[j] <= irq_high_pin_select[j] ? i_port6_in[j] : i_port2_in[j];
            end
        end
    end

    logic [15:0]                       oe_all;
    logic [15:0]                       out_all;
    assign oe_all  = {o_port3_oe, o_port2_oe};
    assign out_all = {o_port3_out, o_port2_out};

    for (genvar g = 0; g < pin_sel_pkg::TMR_FUNCS; g++) begin : g_tmr_chk
        property p_cap_route;
            @(posedge i_clk) disable iff (!i_rst_b)
            $past(i_rst_b) |-> o_capture[g] == ($past(timer_pin_split_select[g])
                ? $past(pin_in[pin_sel_pkg::SEC_PIN[g]]) : $past(pin_in[pin_sel_pkg::PRI_PIN[g]]));
        endproperty
        a_cap_route: assert property (p_cap_route) else $error("capture taken from wrong pin");

        property p_cmp_drive;
            @(posedge i_clk) disable iff (!i_rst_b)
            $past(i_rst_b) |-> oe_all[pin_sel_pkg::PRI_PIN[g]] == $past(i_cmp_oe[g])
                && out_all[pin_sel_pkg::PRI_PIN[g]] == $past(i_cmp_out[g]);
        endproperty
        a_cmp_drive: assert property (p_cmp_drive) else $error("compare not on primary pin");

        property p_sec_quiet;
            @(posedge i_clk) disable iff (!i_rst_b)
            !oe_all[pin_sel_pkg::SEC_PIN[g]];
        endproperty
        a_sec_quiet: assert property (p_sec_quiet) else $error("capture-only pin is driven");
    end

    for (genvar g = 0; g < pin_sel_pkg::IRQ_LINES; g++) begin : g_irq_chk
        property p_irq_route;
            @(posedge i_clk) disable iff (!i_rst_b)
            $past(i_rst_b) |-> o_ext_int[g] ==
                ($past(irq_high_pin_select[g]) ? $past(i_port6_in[g]) : $past(i_port2_in[g]));
        endproperty
        a_irq_route: assert property (p_irq_route) else $error("interrupt line from wrong pin");
    end

    property p_rsv_zero;
        @(posedge i_clk) disable iff (!i_rst_b)
        (setup && !i_apb.pwrite && hit == pin_sel_pkg::HIT_IRQ) |=> o_prdata[31:4] == 28'h0000000;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");

    property p_wr_visible;
        @(posedge i_clk) disable iff (!i_rst_b)
        (access && i_apb.pwrite && hit == pin_sel_pkg::HIT_TIMER)
            |=> timer_pin_split_select == $past(i_apb.pwdata[7:0]) ##1 o_capture == $past(next_capture);
    endproperty
    a_wr_visible: assert property (p_wr_visible) else $error("split write not applied");

    property p_read_back;
        @(posedge i_clk) disable iff (!i_rst_b)
        (setup && !i_apb.pwrite && hit == pin_sel_pkg::HIT_TIMER)
            |=> o_pready && o_prdata[7:0] == timer_pin_split_select;
    endproperty
    a_read_back: assert property (p_read_back) else $error("read-back differs from register");

    property p_pready;
        @(posedge i_clk) disable iff (!i_rst_b)
        setup |=> o_pready ##1 !o_pready;
    endproperty
    a_pready: assert property (p_pready) else $error("pready not a single-cycle answer");

    // pins written out by hand so a slip in the pin tables is caught
    property p_ch5a_pins;
        @(posedge i_clk) disable iff (!i_rst_b)
        $past(i_rst_b) |-> o_port2_oe[6] == $past(i_cmp_oe[7]) && o_port2_out[6] == $past(i_cmp_out[7])
            && !o_port2_oe[7] && o_capture[7] == ($past(timer_pin_split_select[7])
            ? $past(i_port2_in[7]) : $past(i_port2_in[6]));
    endproperty
    a_ch5a_pins: assert property (p_ch5a_pins) else $error("channel 5a pins misrouted");

    property p_ch4a_pins;
        @(posedge i_clk) disable iff (!i_rst_b)
        $past(i_rst_b) |-> o_port2_oe[5] == $past(i_cmp_oe[6]) && o_port2_out[5] == $past(i_cmp_out[6])
            && !o_port2_oe[4] && o_capture[6] == ($past(timer_pin_split_select[6])
            ? $past(i_port2_in[4]) : $past(i_port2_in[5]));
    endproperty
    a_ch4a_pins: assert property (p_ch4a_pins) else $error("channel 4a pins misrouted");

    property p_ch3a_pins;
        @(posedge i_clk) disable iff (!i_rst_b)
        $past(i_rst_b) |-> o_port2_oe[1] == $past(i_cmp_oe[5]) && o_port2_out[1] == $past(i_cmp_out[5])
            && !o_port2_oe[0] && o_capture[5] == ($past(timer_pin_split_select[5])
            ? $past(i_port2_in[0]) : $past(i_port2_in[1]));
    endproperty
    a_ch3a_pins: assert property (p_ch3a_pins) else $error("channel 3a pins misrouted");

    property p_ch3c_pins;
        @(posedge i_clk) disable iff (!i_rst_b)
        $past(i_rst_b) |-> o_port2_oe[2] == $past(i_cmp_oe[4]) && o_port2_out[2] == $past(i_cmp_out[4])
            && !o_port2_oe[3] && o_capture[4] == ($past(timer_pin_split_select[4])
            ? $past(i_port2_in[3]) : $past(i_port2_in[2]));
    endproperty
    a_ch3c_pins: assert property (p_ch3c_pins) else $error("channel 3c pins misrouted");

    property p_ch2a_pins;
        @(posedge i_clk) disable iff (!i_rst_b)
        $past(i_rst_b) |-> o_port3_oe[6] == $past(i_cmp_oe[3]) && o_port3_out[6] == $past(i_cmp_out[3])
            && !o_port3_oe[7] && o_capture[3] == ($past(timer_pin_split_select[3])
            ? $past(i_port3_in[7]) : $past(i_port3_in[6]));
    endproperty
    a_ch2a_pins: assert property (p_ch2a_pins) else $error("channel 2a pins misrouted");

    property p_ch1a_pins;
        @(posedge i_clk) disable iff (!i_rst_b)
        $past(i_rst_b) |-> o_port3_oe[4] == $past(i_cmp_oe[2]) && o_port3_out[4] == $past(i_cmp_out[2])
            && !o_port3_oe[5] && o_capture[2] == ($past(timer_pin_split_select[2])
            ? $past(i_port3_in[5]) : $past(i_port3_in[4]));
    endproperty
    a_ch1a_pins: assert property (p_ch1a_pins) else $error("channel 1a pins misrouted");

    property p_ch0a_pins;
        @(posedge i_clk) disable iff (!i_rst_b)
        $past(i_rst_b) |-> o_port3_oe[0] == $past(i_cmp_oe[1]) && o_port3_out[0] == $past(i_cmp_out[1])
            && !o_port3_oe[1] && o_capture[1] == ($past(timer_pin_split_select[1])
            ? $past(i_port3_in[1]) : $past(i_port3_in[0]));
    endproperty
    a_ch0a_pins: assert property (p_ch0a_pins) else $error("channel 0a pins misrouted");

    property p_ch0c_pins;
        @(posedge i_clk) disable iff (!i_rst_b)
        $past(i_rst_b) |-> o_port3_oe[2] == $past(i_cmp_oe[0]) && o_port3_out[2] == $past(i_cmp_out[0])
            && !o_port3_oe[3] && o_capture[0] == ($past(timer_pin_split_select[0])
            ? $past(i_port3_in[3]) : $past(i_port3_in[2]));
    endproperty
    a_ch0c_pins: assert property (p_ch0c_pins) else $error("channel 0c pins misrouted");

    property p_irq_wr_visible;
        @(posedge i_clk) disable iff (!i_rst_b)
        (access && i_apb.pwrite && hit == pin_sel_pkg::HIT_IRQ)
            |=> irq_high_pin_select == $past(i_apb.pwdata[3:0]);
    endproperty
    a_irq_wr_visible: assert property (p_irq_wr_visible) else $error("irq select write not applied");

    property p_irq_read_back;
        @(posedge i_clk) disable iff (!i_rst_b)
        (setup && !i_apb.pwrite && hit == pin_sel_pkg::HIT_IRQ)
            |=> o_pready && o_prdata[3:0] == irq_high_pin_select;
    endproperty
    a_irq_read_back: assert property (p_irq_read_back) else $error("irq read-back differs from register");

    property p_slverr_decode;
        @(posedge i_clk) disable iff (!i_rst_b)
        setup |=> o_pslverr == $past(hit == pin_sel_pkg::HIT_NONE);
    endproperty
    a_slverr_decode: assert property (p_slverr_decode) else $error("slave error does not match decode");

    property p_unmapped_hold;
        @(posedge i_clk) disable iff (!i_rst_b)
        (access && hit == pin_sel_pkg::HIT_NONE)
            |=> $stable(timer_pin_split_select) && $stable(irq_high_pin_select);
    endproperty
    a_unmapped_hold: assert property (p_unmapped_hold) else $error("unmapped access changed a select");

    property p_answer_idle;
        @(posedge i_clk) disable iff (!i_rst_b)
        !o_pready |-> o_prdata == pin_sel_pkg::RDATA_IDLE && !o_pslverr;
    endproperty
    a_answer_idle: assert property (p_answer_idle) else $error("answer lines busy without pready");

    property p_write_no_data;
        @(posedge i_clk) disable iff (!i_rst_b)
        (setup && i_apb.pwrite) |=> o_prdata == pin_sel_pkg::RDATA_IDLE;
    endproperty
    a_write_no_data: assert property (p_write_no_data) else $error("read data shown on a write");

    property p_reset_clear;
        @(posedge i_clk)
        !i_rst_b |=> timer_pin_split_select == pin_sel_pkg::TIMER_SEL_RESET
            && irq_high_pin_select == pin_sel_pkg::IRQ_SEL_RESET && !o_pready && o_ext_int == 4'h0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear the selects");

    property p_ready_after_setup;
        @(posedge i_clk) disable iff (!i_rst_b)
        o_pready |-> $past(setup);
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready without a setup");

endmodule // timer_and_irq_pin_select

//--- test/tb_top.sv
// self-checking bench for the timer and interrupt pin select block
`timescale 1ns/1ps
module tb_top;
    typedef struct {logic rd; logic [31:0] data; logic err;} apb_exp_s;
    logic                  i_clk    = 1'b0;
    logic                  i_rst_b  = 1'b0;
    pin_sel_pkg::apb_req_s req      = '0;
    logic [7:0]            p2       = 8'h00;
    logic [7:0]            p3       = 8'h00;
    logic [7:0]            cout     = 8'h00;
    logic [7:0]            coe      = 8'h00;
    logic [3:0]            p6       = 4'h0;
    logic [7:0]            cap, p2o, p2e, p3o, p3e, tsel;
    logic [3:0]            eint, isel;
    logic                  pready, pslverr;
    logic [31:0]           prdata;
    apb_exp_s              expq[$];
    int                    miscompares = 0;
    int                    num_checks  = 0;
    // own pin map, kept apart from the package tables so a typo there shows up
    int                    pri[8] = '{10, 8, 12, 14, 2, 1, 5, 6};
    int                    sec[8] = '{11, 9, 13, 15, 3, 0, 4, 7};

    always #25 i_clk = ~i_clk;

    timer_and_irq_pin_select dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_apb(req), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_port2_in(p2), .i_port3_in(p3), .i_port6_in(p6),
        .i_cmp_out(cout), .i_cmp_oe(coe), .o_capture(cap), .o_port2_out(p2o), .o_port2_oe(p2e),
        .o_port3_out(p3o), .o_port3_oe(p3e), .o_ext_int(eint));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk_pin(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic chk_apb(input apb_exp_s e, input logic [31:0] d, input logic err);
        num_checks++;
        if (err !== e.err || (e.rd && d !== e.data)) begin
            miscompares++;
            $display("mismatch apb expected %0h/%0b seen %0h/%0b", e.data, e.err, d, err);
        end
    endtask

    // answer sampled on the same edge the master sees pready
    always @(posedge i_clk) begin : mon
        if (pready === 1'b1) begin
            if (expq.size() == 0) chk_pin("apb_queue", 1, 0);
            else chk_apb(expq.pop_front(), prdata, pslverr);
        end
    end

    // one setup cycle, then access until pready; an idle edge precedes each setup
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic err);
        int n;
        expq.push_back('{!wr, e, err});
        @(posedge i_clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge i_clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            print_verdict();
        end else begin
            req.psel <= 1'b0;
            req.penable <= 1'b0;
        end
    endtask

    task automatic check_routing();
        logic [15:0] pins, oe16, out16;
        logic [7:0]  ecap;
        repeat (2) @(posedge i_clk);
        #1;
        pins = {p3, p2};
        oe16 = '0;
        out16 = '0;
        for (int k = 0; k < 8; k++) begin
            ecap[k] = tsel[k] ? pins[sec[k]] : pins[pri[k]];
            oe16[pri[k]] = coe[k];
            out16[pri[k]] = cout[k];
        end
        chk_pin("capture", ecap, cap);
        chk_pin("pin_oe", oe16, {p3e, p2e});
        chk_pin("pin_out", out16, {p3o, p2o});
        chk_pin("ext_int", (isel & p6) | (~isel & p2[3:0]), eint);
    endtask

    initial begin
        void'($urandom(54736));
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        apb(1'b0, pin_sel_pkg::ADDR_TIMER_SEL, 0, 32'(pin_sel_pkg::TIMER_SEL_RESET), 1'b0);
        apb(1'b0, pin_sel_pkg::ADDR_IRQ_SEL, 0, 32'(pin_sel_pkg::IRQ_SEL_RESET), 1'b0);
        $display("test reset values done");
        for (int i = 0; i < 24; i++) begin
            tsel = (i == 1) ? 8'hFF : 8'($urandom);
            isel = (i == 1) ? 4'hF : 4'($urandom);
            apb(1'b1, pin_sel_pkg::ADDR_TIMER_SEL, {24'h0, tsel}, 0, 1'b0);
            apb(1'b1, pin_sel_pkg::ADDR_IRQ_SEL, {28'h0, isel}, 0, 1'b0);
            apb(1'b0, pin_sel_pkg::ADDR_TIMER_SEL, 0, {24'h0, tsel}, 1'b0);
            apb(1'b0, pin_sel_pkg::ADDR_IRQ_SEL, 0, {28'h0, isel}, 1'b0);
            p2 <= 8'($urandom);
            p3 <= 8'($urandom);
            p6 <= 4'($urandom);
            cout <= 8'($urandom);
            coe <= 8'($urandom);
            check_routing();
        end
        $display("test random routing done");
        // unmapped write must leave the timer selects alone
        apb(1'b1, 12'h00C, 32'hFFFFFFFF, 0, 1'b1);
        apb(1'b0, 12'h008, 0, 0, 1'b1);
        apb(1'b0, pin_sel_pkg::ADDR_TIMER_SEL, 0, {24'h0, tsel}, 1'b0);
        $display("test unmapped address done");
        // reset in mid-run must bring both selects back to shared pins
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        tsel = pin_sel_pkg::TIMER_SEL_RESET;
        isel = pin_sel_pkg::IRQ_SEL_RESET;
        apb(1'b0, pin_sel_pkg::ADDR_TIMER_SEL, 0, 32'(pin_sel_pkg::TIMER_SEL_RESET), 1'b0);
        apb(1'b0, pin_sel_pkg::ADDR_IRQ_SEL, 0, 32'(pin_sel_pkg::IRQ_SEL_RESET), 1'b0);
        check_routing();
        $display("test mid-run reset done");
        repeat (2) @(posedge i_clk);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        miscompares++;
        print_verdict();
    end
endmodule // tb_top
